// ### verilog/bpu_defs.vh
// Constants of the bus cycle breakpoint unit
`ifndef BPU_DEFS_VH
`define BPU_DEFS_VH

// ****************************************
// Register map
// ****************************************
`define BPU_BASE_ADDR 32'hFFFFEC00
`define BPU_OFS_ADDR_HI 32'hFFFFEC00
`define BPU_OFS_ADDR_LO 32'hFFFFEC02
`define BPU_OFS_MASK_HI 32'hFFFFEC04
`define BPU_OFS_MASK_LO 32'hFFFFEC06
`define BPU_OFS_CYC_SEL 32'hFFFFEC08
`define BPU_OFS_CTRL 32'hFFFFEC0A
`define BPU_LAST_HW 3'h5
`define BPU_NUM_REGS 6

// Halfword indices inside the block
`define BPU_IDX_ADDR_HI 3'h0
`define BPU_IDX_ADDR_LO 3'h1
`define BPU_IDX_MASK_HI 3'h2
`define BPU_IDX_MASK_LO 3'h3
`define BPU_IDX_CYC_SEL 3'h4
`define BPU_IDX_CTRL 3'h5

// ****************************************
// Reset values and writable bits
// ****************************************
`define BPU_RST_VAL 16'h0000
`define BPU_WMASK_FULL 16'hFFFF
`define BPU_WMASK_CYC_SEL 16'h00FF
`define BPU_WMASK_CTRL 16'h0007

// ****************************************
// Field positions
// ****************************************
`define BPU_ORIG_HI 7
`define BPU_ORIG_LO 6
`define BPU_FETCH_HI 5
`define BPU_FETCH_LO 4
`define BPU_DIR_HI 3
`define BPU_DIR_LO 2
`define BPU_SIZE_HI 1
`define BPU_SIZE_LO 0
`define BPU_PW_HI 2
`define BPU_PW_LO 1
`define BPU_IRQ_DIS 0

// ****************************************
// Access and operand size codes
// ****************************************
`define BPU_SZ_NONE 2'h0
`define BPU_SZ_BYTE 2'h1
`define BPU_SZ_WORD 2'h2
`define BPU_SZ_LONG 2'h3

// ****************************************
// Timing counts, in clock cycles
// ****************************************
`define BPU_ACC_SHORT_CYC 3'h3
`define BPU_ACC_LONG_CYC 3'h6
`define BPU_PW_1 4'h1
`define BPU_PW_4 4'h4
`define BPU_PW_8 4'h8
`define BPU_PW_16 5'h10

`endif

// ### verilog/bpu_pulse_gen.v
// Trigger pin pulse stretcher of the breakpoint unit
`timescale 1ns/10ps
`include "bpu_defs.vh"

module bpu_pulse_gen (
  input wire clk, // 40 MHz system clock
  input wire rst_n, // synchronous reset, active low
  input wire clr, // module standby clear
  input wire start, // one-cycle match event
  input wire [1:0] width_sel, // pulse width select
  output reg trig_n_q // trigger pin, active low
);

  reg [3:0] cnt_q;
  reg [3:0] load_val;
  // Sixteen needs five bits; its count minus one fits in four
  wire [4:0] pw16_m1;

  assign pw16_m1 = `BPU_PW_16 - 5'h01;

  // ****************************************
  // Width lookup, loaded as width minus one
  // ****************************************
  always @* begin
    case (width_sel)
      2'h0: load_val = `BPU_PW_1 - 4'h1;
      2'h1: load_val = `BPU_PW_4 - 4'h1;
      2'h2: load_val = `BPU_PW_8 - 4'h1;
      default: load_val = pw16_m1[3:0];
    endcase
  end

  // Retrigger restarts the full width so back to back matches merge
  always @(posedge clk) begin
    if (!rst_n || clr) begin
      trig_n_q <= 1'b1;
      cnt_q <= 4'h0;
    end else if (start) begin
      trig_n_q <= 1'b0;
      cnt_q <= load_val;
    end else if (!trig_n_q) begin
      if (cnt_q == 4'h0) begin
        trig_n_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end

endmodule

// ### verilog/bpu_top.v
// Bus cycle breakpoint unit: registers, cycle compare, break request
`timescale 1ns/10ps
`include "bpu_defs.vh"

module bpu_top (
  input wire clk, // 40 MHz system clock
  input wire rst_n, // synchronous reset, active low
  input wire module_standby, // module standby, clears registers
  input wire reg_req, // register access request, one cycle
  input wire reg_we, // 1 write, 0 read
  input wire [1:0] reg_size, // 1 byte, 2 word, 3 longword
  input wire [31:0] reg_addr, // byte address of the access
  input wire [31:0] reg_wdata, // write data, low aligned
  output reg [31:0] reg_rdata_q, // read data, low aligned
  output reg reg_ack_q, // access done, one cycle
  output reg reg_busy_q, // access in progress
  input wire bus_valid, // a bus cycle is present this clock
  input wire [31:0] bus_addr, // bus cycle address
  input wire bus_dma, // 1 DMA cycle, 0 core cycle
  input wire bus_fetch, // 1 instruction fetch, 0 data access
  input wire bus_write, // 1 write, 0 read
  input wire [1:0] bus_size, // 1 byte, 2 word, 3 longword
  input wire fetch_break_after, // fetch breaks wait for execution
  input wire insn_done, // fetched instruction finished executing
  output reg break_irq_q, // break request to interrupt control
  output wire match_trigger_out_n // trigger pin, active low pulse
);

  // ****************************************
  // Register storage
  // ****************************************
  reg [15:0] regs_q [0:`BPU_NUM_REGS-1];
  wire [15:0] wmask [0:`BPU_NUM_REGS-1];
  wire [15:0] wdata_hw [0:`BPU_NUM_REGS-1];
  wire [15:0] lane_mask [0:`BPU_NUM_REGS-1];
  wire [`BPU_NUM_REGS-1:0] hw_sel;

  // ****************************************
  // Access sequencer state
  // ****************************************
  reg [31:0] acc_addr_q;
  reg [31:0] acc_wdata_q;
  reg [1:0] acc_size_q;
  reg acc_we_q;
  reg [2:0] acc_cnt_q;
  reg [2:0] acc_last;
  wire acc_done;
  wire acc_in_range;
  wire acc_long;
  wire [2:0] acc_idx;
  wire [2:0] acc_idx_pair;
  wire [31:0] base_addr;
  wire [15:0] rd_word;
  wire [7:0] idx_dec;
  wire [7:0] pair_dec;
  reg [31:0] rdata_d;

  // ****************************************
  // Compare state
  // ****************************************
  wire [31:0] brk_addr;
  wire [31:0] brk_mask;
  wire [15:0] cyc_sel;
  wire [15:0] ctrl;
  wire addr_ok;
  wire orig_ok;
  wire fetch_ok;
  wire dir_ok;
  wire size_ok;
  wire fields_set;
  wire hit;
  reg pend_q;
  wire fire;
  reg fire_q;

  // ****************************************
  // Halfword read helper
  // ****************************************
  function [15:0] rd_hw;
    input [2:0] idx;
    begin
      case (idx)
        `BPU_IDX_ADDR_HI: rd_hw = regs_q[0];
        `BPU_IDX_ADDR_LO: rd_hw = regs_q[1];
        `BPU_IDX_MASK_HI: rd_hw = regs_q[2];
        `BPU_IDX_MASK_LO: rd_hw = regs_q[3];
        `BPU_IDX_CYC_SEL: rd_hw = regs_q[4];
        `BPU_IDX_CTRL: rd_hw = regs_q[5];
        default: rd_hw = 16'h0000;
      endcase
    end
  endfunction

  // ****************************************
  // Address decode of the latched access
  // ****************************************
  assign acc_long = (acc_size_q == `BPU_SZ_LONG);
  assign acc_idx = acc_addr_q[3:1];
  assign acc_idx_pair = {acc_addr_q[3:2], 1'b0};
  assign base_addr = `BPU_BASE_ADDR;
  assign rd_word = rd_hw(acc_idx);
  // One-hot halfword selects, a pair for a longword
  assign idx_dec = 8'h01 << acc_idx;
  assign pair_dec = 8'h03 << acc_idx_pair;
  // Hole above the last register answers zero and takes no write
  assign acc_in_range = (acc_addr_q[31:4] == base_addr[31:4])
    && (acc_idx <= `BPU_LAST_HW);
  assign acc_done = reg_busy_q && (acc_cnt_q == acc_last);

  always @* begin
    if (acc_long) begin
      acc_last = `BPU_ACC_LONG_CYC - 3'h1;
    end else begin
      acc_last = `BPU_ACC_SHORT_CYC - 3'h1;
    end
  end

  // ****************************************
  // Per register write lanes
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < `BPU_NUM_REGS; gi = gi + 1) begin : g_reg
      // Reserved bits never store, so they read as zero
      if (gi == `BPU_IDX_CYC_SEL) begin : g_cs
        assign wmask[gi] = `BPU_WMASK_CYC_SEL;
      end else if (gi == `BPU_IDX_CTRL) begin : g_ct
        assign wmask[gi] = `BPU_WMASK_CTRL;
      end else begin : g_full
        assign wmask[gi] = `BPU_WMASK_FULL;
      end

      // Longword covers an aligned pair, lower address word first
      assign hw_sel[gi] = acc_in_range && (acc_long ?
        pair_dec[gi] : idx_dec[gi]);

      assign wdata_hw[gi] = acc_long ?
        ((gi % 2 == 0) ? acc_wdata_q[31:16] : acc_wdata_q[15:0]) :
        ((acc_size_q == `BPU_SZ_BYTE) ?
          {acc_wdata_q[7:0], acc_wdata_q[7:0]} : acc_wdata_q[15:0]);

      // Even byte address is the upper byte of a halfword
      assign lane_mask[gi] = wmask[gi] &
        ((acc_size_q == `BPU_SZ_BYTE) ?
          (acc_addr_q[0] ? 16'h00FF : 16'hFF00) : 16'hFFFF);

      always @(posedge clk) begin
        if (!rst_n || module_standby) begin
          regs_q[gi] <= `BPU_RST_VAL;
        end else if (acc_done && acc_we_q && hw_sel[gi]) begin
          regs_q[gi] <= (regs_q[gi] & ~lane_mask[gi]) |
            (wdata_hw[gi] & lane_mask[gi]);
        end
      end
    end
  endgenerate

  // ****************************************
  // Read data, low aligned
  // ****************************************
  always @* begin
    rdata_d = 32'h00000000;
    if (acc_in_range) begin
      case (acc_size_q)
        `BPU_SZ_LONG: rdata_d = {rd_hw(acc_idx_pair), rd_hw(acc_idx_pair + 3'h1)};
        `BPU_SZ_WORD: rdata_d = {16'h0000, rd_hw(acc_idx)};
        `BPU_SZ_BYTE: begin
          if (acc_addr_q[0]) begin
            rdata_d = {24'h000000, rd_word[7:0]};
          end else begin
            rdata_d = {24'h000000, rd_word[15:8]};
          end
        end
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // Access sequencer
  // ****************************************
  // Requests while busy are ignored; the master waits for ack
  always @(posedge clk) begin
    if (!rst_n) begin
      reg_busy_q <= 1'b0;
      reg_ack_q <= 1'b0;
      reg_rdata_q <= 32'h00000000;
      acc_cnt_q <= 3'h0;
      acc_addr_q <= 32'h00000000;
      acc_wdata_q <= 32'h00000000;
      acc_size_q <= `BPU_SZ_NONE;
      acc_we_q <= 1'b0;
    end else begin
      reg_ack_q <= 1'b0;
      if (!reg_busy_q) begin
        if (reg_req) begin
          reg_busy_q <= 1'b1;
          acc_cnt_q <= 3'h1;
          acc_addr_q <= reg_addr;
          acc_wdata_q <= reg_wdata;
          acc_size_q <= (reg_size == `BPU_SZ_NONE) ? `BPU_SZ_WORD : reg_size;
          acc_we_q <= reg_we;
        end
      end else if (acc_done) begin
        reg_busy_q <= 1'b0;
        reg_ack_q <= 1'b1;
        acc_cnt_q <= 3'h0;
        if (acc_we_q) begin
          reg_rdata_q <= 32'h00000000;
        end else begin
          reg_rdata_q <= rdata_d;
        end
      end else begin
        acc_cnt_q <= acc_cnt_q + 3'h1;
      end
    end
  end

  // ****************************************
  // Bus cycle compare
  // ****************************************
  assign brk_addr = {regs_q[0], regs_q[1]};
  assign brk_mask = {regs_q[2], regs_q[3]};
  assign cyc_sel = regs_q[4];
  assign ctrl = regs_q[5];

  // Mask 1 drops the bit from the compare
  assign addr_ok = &(~(bus_addr ^ brk_addr) | brk_mask);

  assign orig_ok = bus_dma ? cyc_sel[`BPU_ORIG_HI] :
    cyc_sel[`BPU_ORIG_LO];
  assign fetch_ok = bus_fetch ? cyc_sel[`BPU_FETCH_LO] :
    cyc_sel[`BPU_FETCH_HI];
  assign dir_ok = bus_write ? cyc_sel[`BPU_DIR_HI] :
    cyc_sel[`BPU_DIR_LO];
  // Fetches report word size, so a fetch break needs size 00 or word
  assign size_ok = (cyc_sel[`BPU_SIZE_HI:`BPU_SIZE_LO] == `BPU_SZ_NONE) ||
    (cyc_sel[`BPU_SIZE_HI:`BPU_SIZE_LO] == bus_size);

  assign fields_set = (|cyc_sel[`BPU_ORIG_HI:`BPU_ORIG_LO]) &&
    (|cyc_sel[`BPU_FETCH_HI:`BPU_FETCH_LO]) &&
    (|cyc_sel[`BPU_DIR_HI:`BPU_DIR_LO]);

  assign hit = bus_valid && fields_set && addr_ok && orig_ok && fetch_ok &&
    dir_ok && size_ok;

  // ****************************************
  // Before or after execution of a fetch
  // ****************************************
  // Only one deferred fetch break is held; a new one merges with it
  assign fire = (hit && !(bus_fetch && fetch_break_after)) ||
    (pend_q && insn_done);

  always @(posedge clk) begin
    if (!rst_n || module_standby) begin
      pend_q <= 1'b0;
    end else if (hit && bus_fetch && fetch_break_after) begin
      pend_q <= 1'b1;
    end else if (insn_done) begin
      pend_q <= 1'b0;
    end
  end

  // ****************************************
  // Break request and trigger
  // ****************************************
  always @(posedge clk) begin
    if (!rst_n || module_standby) begin
      break_irq_q <= 1'b0;
      fire_q <= 1'b0;
    end else begin
      fire_q <= fire;
      break_irq_q <= fire && !ctrl[`BPU_IRQ_DIS];
    end
  end

  // Trigger follows every match even with the request disabled
  bpu_pulse_gen u_pulse (
    .clk(clk),
    .rst_n(rst_n),
    .clr(module_standby),
    .start(fire_q),
    .width_sel(ctrl[`BPU_PW_HI:`BPU_PW_LO]),
    .trig_n_q(match_trigger_out_n)
  );

endmodule

// ### testbench/bpu_bus_model.sv
// Core and DMA engine bus cycle source facing the breakpoint unit
`timescale 1ns/10ps
`include "bpu_defs.vh"
module bpu_bus_model (
  input wire clk, // clock
  input wire go, // issue a cycle
  input wire [31:0] addr, // address
  input wire dma, // 1 DMA
  input wire fetch, // 1 fetch
  input wire write, // 1 write
  input wire [1:0] size, // size
  output reg bus_valid, // cycle present
  output reg [31:0] bus_addr, // address
  output reg bus_dma, // origin
  output reg bus_fetch, // kind
  output reg bus_write, // direction
  output reg [1:0] bus_size // size
);
  // ****
  // Cycle issue
  // ****
  initial {bus_valid, bus_addr, bus_dma, bus_fetch, bus_write, bus_size} = 38'h0;
  // Idle cycles invert qualifiers so stale values never match by luck
  always @(posedge clk) begin
    bus_valid <= go;
    bus_addr <= go ? addr : ~bus_addr;
    bus_dma <= go ? dma : ~bus_dma;
    bus_fetch <= go ? fetch : ~bus_fetch;
    bus_write <= go ? write : ~bus_write;
    bus_size <= go ? (fetch ? `BPU_SZ_WORD : size) : ~bus_size;
  end
endmodule

// ### testbench/bpu_top_properties.sv
// Port checks of the breakpoint unit
`timescale 1ns/10ps
`include "bpu_defs.vh"
module bpu_top_properties (
  input wire clk, // clock
  input wire rst_n, // reset
  input wire module_standby, // standby
  input wire reg_req, // request
  input wire reg_we, // write
  input wire [1:0] reg_size, // size
  input wire [31:0] reg_addr, // address
  input wire [31:0] reg_wdata, // data
  input wire [31:0] reg_rdata_q, // read data
  input wire reg_ack_q, // done
  input wire reg_busy_q, // busy
  input wire bus_valid, // cycle
  input wire [31:0] bus_addr, // address
  input wire bus_dma, // origin
  input wire bus_fetch, // kind
  input wire bus_write, // direction
  input wire [1:0] bus_size, // size
  input wire fetch_break_after, // defer
  input wire insn_done, // executed
  input wire break_irq_q, // request
  input wire match_trigger_out_n // trigger
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence take_s;
    reg_req && !reg_busy_q && !reg_ack_q;
  endsequence
  sequence short_s;
    take_s ##0 reg_size != `BPU_SZ_LONG;
  endsequence
  sequence long_s;
    take_s ##0 reg_size == `BPU_SZ_LONG;
  endsequence
  short_ack_a: assert property (short_s |=> (reg_busy_q && !reg_ack_q) [*2] ##1 reg_ack_q)
    else $error("short access not done in three cycles");
  long_ack_a: assert property (long_s |=> (reg_busy_q && !reg_ack_q) [*5] ##1 reg_ack_q)
    else $error("long access not done in six cycles");
  ack_pulse_a: assert property (reg_ack_q |=> !reg_ack_q)
    else $error("ack longer than one cycle");
  rdata_hold_a: assert property (!reg_ack_q && $past(rst_n) && !$past(module_standby)
    |-> $stable(reg_rdata_q)) else $error("read data moved outside ack");
  unmapped_zero_a: assert property (take_s ##0 (!reg_we && reg_addr[31:4] != 28'hFFFFEC0)
    |-> ##[3:6] (reg_ack_q && reg_rdata_q == 32'h0)) else $error("unmapped read not zero");
  irq_cause_a: assert property (break_irq_q |-> $past(bus_valid) || $past(insn_done))
    else $error("request without a bus cycle");
  irq_trig_a: assert property (break_irq_q && !module_standby
    |=> module_standby || !match_trigger_out_n) else $error("request without trigger");
  trig_cause_a: assert property ($fell(match_trigger_out_n)
    |-> $past(bus_valid, 2) || $past(insn_done, 2)) else $error("trigger without a bus cycle");
  standby_clr_a: assert property (module_standby
    |=> !break_irq_q && match_trigger_out_n) else $error("standby left outputs active");
  reset_out_a: assert property ($rose(rst_n)
    |-> !break_irq_q && match_trigger_out_n && !reg_busy_q) else $error("bad reset outputs");
endmodule
bind bpu_top bpu_top_properties chk_u (.clk(clk), .rst_n(rst_n),
  .module_standby(module_standby), .reg_req(reg_req), .reg_we(reg_we), .reg_size(reg_size),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_ack_q(reg_ack_q),
  .reg_busy_q(reg_busy_q), .bus_valid(bus_valid), .bus_addr(bus_addr), .bus_dma(bus_dma),
  .bus_fetch(bus_fetch), .bus_write(bus_write), .bus_size(bus_size), .insn_done(insn_done),
  .fetch_break_after(fetch_break_after), .break_irq_q(break_irq_q),
  .match_trigger_out_n(match_trigger_out_n));

// ### testbench/bpu_top_test.sv
// Self-checking bench of the breakpoint unit
`timescale 1ns/10ps
`include "bpu_defs.vh"
module bpu_top_test;
  reg clk = 1'b0, rst_n = 1'b0, module_standby = 1'b0, reg_req = 1'b0, reg_we = 1'b0;
  reg [1:0] reg_size = 2'h0, c_size = 2'h0;
  reg [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, c_addr = 32'h0, rd;
  reg go = 1'b0, c_dma = 1'b0, c_fetch = 1'b0, c_write = 1'b0;
  reg fetch_break_after = 1'b0, insn_done = 1'b0, irq_s, trig_s;
  reg [45:0] rows [0:12];
  wire [31:0] reg_rdata_q, bus_addr;
  wire [1:0] bus_size;
  wire reg_ack_q, reg_busy_q, bus_valid, bus_dma, bus_fetch, bus_write;
  wire break_irq_q, match_trigger_out_n;
  integer fails = 0, tests_run = 0, i, n;
  always #12.5 clk = ~clk;
  bpu_top dut_u (.clk(clk), .rst_n(rst_n), .module_standby(module_standby),
    .reg_req(reg_req), .reg_we(reg_we), .reg_size(reg_size), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_ack_q(reg_ack_q),
    .reg_busy_q(reg_busy_q), .bus_valid(bus_valid), .bus_addr(bus_addr), .bus_dma(bus_dma),
    .bus_fetch(bus_fetch), .bus_write(bus_write), .bus_size(bus_size), .insn_done(insn_done),
    .fetch_break_after(fetch_break_after), .break_irq_q(break_irq_q),
    .match_trigger_out_n(match_trigger_out_n));
  bpu_bus_model bus_u (.clk(clk), .go(go), .addr(c_addr), .dma(c_dma), .fetch(c_fetch),
    .write(c_write), .size(c_size), .bus_valid(bus_valid), .bus_addr(bus_addr),
    .bus_dma(bus_dma), .bus_fetch(bus_fetch), .bus_write(bus_write), .bus_size(bus_size));
  // ****
  // Tasks
  // ****
  task check(input [255:0] what, input [31:0] exp, input [31:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[FAIL] %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task acc(input we, input [1:0] sz, input [31:0] a, input [31:0] wd);
    begin
      @(posedge clk);
      reg_req <= 1'b1;
      reg_we <= we;
      reg_size <= sz;
      reg_addr <= a;
      reg_wdata <= wd;
      @(posedge clk);
      reg_req <= 1'b0;
      n = 0;
      #1;
      while (reg_ack_q !== 1'b1 && n < 12) begin
        @(posedge clk);
        #1 n = n + 1;
      end
      rd = reg_rdata_q;
      check("access cycles", sz == `BPU_SZ_LONG ? 5 : 2, n);
    end
  endtask
  task cyc(input [31:0] a, input d, input f, input w, input [1:0] s);
    begin
      @(posedge clk);
      go <= 1'b1;
      c_addr <= a;
      c_dma <= d;
      c_fetch <= f;
      c_write <= w;
      c_size <= s;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      #1 irq_s = break_irq_q;
      @(posedge clk);
      #1 trig_s = match_trigger_out_n;
    end
  endtask
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #200000;
    fails = fails + 1;
    test_done;
  end
  // ****
  // Sequence
  // ****
  initial begin
    // Select, address, dma fetch write, size, break expected
    rows[0] = {8'h56, 32'h12345678, 3'b010, 2'h2, 1'b1};
    rows[1] = {8'hA9, 32'h1234567F, 3'b101, 2'h1, 1'b1};
    rows[2] = {8'hA9, 32'h12345668, 3'b101, 2'h1, 1'b0};
    rows[3] = {8'hFF, 32'h12345670, 3'b000, 2'h3, 1'b1};
    rows[4] = {8'hFF, 32'h12345670, 3'b000, 2'h2, 1'b0};
    rows[5] = {8'hFC, 32'h12345671, 3'b100, 2'h1, 1'b1};
    rows[6] = {8'h3F, 32'h12345678, 3'b000, 2'h3, 1'b0};
    rows[7] = {8'hCF, 32'h12345678, 3'b000, 2'h3, 1'b0};
    rows[8] = {8'hF3, 32'h12345678, 3'b000, 2'h3, 1'b0};
    rows[9] = {8'h56, 32'h12345678, 3'b110, 2'h2, 1'b0};
    rows[10] = {8'hFC, 32'h92345678, 3'b000, 2'h1, 1'b0};
    rows[11] = {8'h6A, 32'h12345678, 3'b001, 2'h2, 1'b1};
    rows[12] = {8'h94, 32'h12345678, 3'b110, 2'h2, 1'b1};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 6; i = i + 1) begin
      acc(1'b0, `BPU_SZ_WORD, `BPU_BASE_ADDR + 2 * i, 32'h0);
      check("reset value", 32'h0, rd);
      acc(1'b1, `BPU_SZ_WORD, `BPU_BASE_ADDR + 2 * i, 32'hFFFF);
      acc(1'b0, `BPU_SZ_WORD, `BPU_BASE_ADDR + 2 * i, 32'h0);
      check("writable bits", i < 4 ? `BPU_WMASK_FULL : (i == 4 ? `BPU_WMASK_CYC_SEL :
        `BPU_WMASK_CTRL), rd);
    end
    acc(1'b1, `BPU_SZ_LONG, `BPU_OFS_ADDR_HI, 32'h12345678);
    acc(1'b0, `BPU_SZ_WORD, `BPU_OFS_ADDR_HI, 32'h0);
    check("address high", 32'h1234, rd);
    acc(1'b0, `BPU_SZ_WORD, `BPU_OFS_ADDR_LO, 32'h0);
    check("address low", 32'h5678, rd);
    acc(1'b0, `BPU_SZ_LONG, `BPU_OFS_ADDR_HI, 32'h0);
    check("long read", 32'h12345678, rd);
    acc(1'b0, `BPU_SZ_BYTE, 32'hFFFFEC01, 32'h0);
    check("byte read", 32'h34, rd);
    acc(1'b1, `BPU_SZ_WORD, 32'hFFFFEC10, 32'hFFFF);
    acc(1'b0, `BPU_SZ_WORD, 32'hFFFFEC10, 32'h0);
    check("unmapped read", 32'h0, rd);
    acc(1'b1, `BPU_SZ_LONG, `BPU_OFS_MASK_HI, 32'h0000000F);
    acc(1'b1, `BPU_SZ_WORD, `BPU_OFS_CTRL, 32'h0);
    $display("register tests done");
    for (i = 0; i < 13; i = i + 1) begin
      acc(1'b1, `BPU_SZ_WORD, `BPU_OFS_CYC_SEL, {24'h0, rows[i][45:38]});
      cyc(rows[i][37:6], rows[i][5], rows[i][4], rows[i][3], rows[i][2:1]);
      check("row irq", rows[i][0], irq_s);
      check("row trigger", !rows[i][0], trig_s);
    end
    $display("row tests done");
    acc(1'b1, `BPU_SZ_WORD, `BPU_OFS_CTRL, 32'h1);
    cyc(32'h12345678, 1'b1, 1'b1, 1'b0, 2'h2);
    check("disabled irq", 32'h0, irq_s);
    check("disabled trigger", 32'h0, trig_s);
    for (i = 0; i < 4; i = i + 1) begin
      acc(1'b1, `BPU_SZ_WORD, `BPU_OFS_CTRL, i << 1);
      cyc(32'h12345678, 1'b1, 1'b1, 1'b0, 2'h2);
      n = 0;
      while (match_trigger_out_n !== 1'b1 && n < 40) begin
        n = n + 1;
        @(posedge clk);
        #1;
      end
      check("pulse width", i == 0 ? 1 : 2 << i, n);
    end
    @(posedge clk);
    fetch_break_after <= 1'b1;
    cyc(32'h12345678, 1'b1, 1'b1, 1'b0, 2'h2);
    check("deferred early irq", 32'h0, irq_s);
    @(posedge clk);
    insn_done <= 1'b1;
    @(posedge clk);
    insn_done <= 1'b0;
    fetch_break_after <= 1'b0;
    #1 check("deferred irq", 32'h1, break_irq_q);
    $display("break tests done");
    @(posedge clk);
    module_standby <= 1'b1;
    @(posedge clk);
    module_standby <= 1'b0;
    acc(1'b0, `BPU_SZ_LONG, `BPU_OFS_ADDR_HI, 32'h0);
    check("standby clear", 32'h0, rd);
    $display("standby test done");
    // Byte lanes, then a size code of zero read back as a word
    acc(1'b1, `BPU_SZ_BYTE, `BPU_OFS_ADDR_HI, 32'hA5);
    acc(1'b1, `BPU_SZ_BYTE, `BPU_OFS_ADDR_HI + 1, 32'h3C);
    acc(1'b0, `BPU_SZ_NONE, `BPU_OFS_ADDR_HI, 32'h0);
    check("byte write", 32'hA53C, rd);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    acc(1'b0, `BPU_SZ_WORD, `BPU_OFS_ADDR_HI, 32'h0);
    check("reset clear", 32'h0, rd);
    $display("byte and reset tests done");
    test_done;
  end
endmodule
